//--- hw/cppf_pkg.sv
/*
  Shared constants and types of the component pixel port formatter.
  Assumes a single core clock of 10 MHz and a word-wide register port.
*/
package cppf_pkg;

  // ==========================================================
  // Widths and depths
  localparam int CH_W       = 10;
  localparam int PIN_W      = 27;
  localparam int WORD_W     = 33;
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_COEF   = 9;
  localparam int CNT_W      = 12;
  localparam int IDLE_W     = 7;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int LINK_TIMEOUT_NS  = 6400;
  localparam int LINK_TIMEOUT_CYC =
    (LINK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_HSYNC = 8'h04;
  localparam logic [7:0] REG_VSYNC = 8'h08;
  localparam logic [7:0] REG_FIELD = 8'h0c;
  localparam logic [7:0] REG_GAIN  = 8'h10;
  localparam logic [7:0] REG_OFFS  = 8'h14;
  localparam logic [7:0] REG_COEF0 = 8'h18;
  localparam logic [7:0] REG_COFS  = 8'h3c;
  localparam logic [7:0] REG_STAT  = 8'h40;
  localparam logic [7:0] REG_IMASK = 8'h44;
  localparam logic [7:0] REG_IPEND = 8'h48;

  // ==========================================================
  // Field positions
  localparam int CTRL_FMT_LSB  = 0;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CTRL_DE_SEL   = 5;
  localparam int CTRL_EMB_SYNC = 6;
  localparam int CTRL_GAIN_MAN = 7;
  localparam int CTRL_OFFS_MAN = 8;
  localparam int CTRL_EN       = 9;
  localparam int SYNC_WID_LSB  = 12;
  localparam int SYNC_POL      = 24;
  localparam int STAT_LINK     = 0;
  localparam int STAT_OVF      = 1;
  localparam int STAT_GAIN_LSB = 12;

  // ==========================================================
  // Reset values and levels
  localparam logic [9:0]  CTRL_RST    = 10'h000;
  localparam logic [24:0] HSYNC_RST   = 25'h0020000;
  localparam logic [24:0] VSYNC_RST   = 25'h0003000;
  localparam logic [11:0] COEF_UNITY  = 12'h100;
  localparam logic [9:0]  GAIN_RST    = 10'h100;
  localparam logic [9:0]  BLANK_LEVEL = 10'h040;
  localparam logic [9:0]  PEAK_TARGET = 10'h3ac;
  localparam logic [9:0]  CHROMA_MID  = 10'h200;
  localparam logic [9:0]  CH_MAX      = 10'h3ff;

  // ==========================================================
  // Modes
  typedef enum logic [2:0] {
    FMT_SDR16 = 3'h0, FMT_SDR20 = 3'h1, FMT_SDR24 = 3'h2,
    FMT_SDR30 = 3'h3, FMT_DDR8  = 3'h4, FMT_DDR10 = 3'h5,
    FMT_DDR12 = 3'h6
  } cppf_fmt_t;

  typedef enum logic [1:0] {
    IN_RGB24 = 2'h0, IN_YC444 = 2'h1, IN_YC422 = 2'h2, IN_CVBS = 2'h3
  } cppf_in_t;

  typedef enum logic {PH_LO = 1'b0, PH_HI = 1'b1} cppf_ph_t;

endpackage

//--- hw/cppf_top.sv
/*
  Component pixel port formatter: digital input port sampling, colour
  matrix, gain and clamp, pixel FIFO and output formatter: SDR/DDR in CVBS mode, SDR16 in the other input modes.
  Assumes the link clock is slow enough to be oversampled by core_clk
  and that software programs the block through the plain register port.
*/
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// ============================================================
// Pixel FIFO
module cppf_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  logic             core_clk,
  input  logic             rst,
  // Fill side
  input  logic             in_valid,
  output logic             in_ready,
  input  logic [WIDTH-1:0] in_data,
  // Drain side
  output logic             out_valid,
  input  logic             out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } cppf_fifo_st_t;
  cppf_fifo_st_t s_q;
  cppf_fifo_st_t s_d;
  logic          push;
  logic          pop;

  assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = s_q.wp + 1'b1;
    end
    if (pop)
      s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

// ============================================================
// Top
module cppf_top
  import cppf_pkg::*;
(
  // Clock and reset
  input  logic        core_clk,
  input  logic        rst,
  // Register port
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  // Digital input port
  input  logic        digital_port_clock_in,
  input  logic [23:0] pixel_data_in,
  input  logic        line_sync_in,
  input  logic        frame_sync_in,
  input  logic        pixel_valid_in,
  // Pixel output port
  output logic        line_locked_pixel_clock,
  output logic [29:0] pixel_out,
  output logic        hsync_out,
  output logic        vsync_out,
  output logic        field_or_valid_out,
  // Status
  output logic        irq_out
);
  typedef struct packed {
    logic [1:0]                     lclk_s;
    logic [PIN_W-1:0]               pin_s0;
    logic [PIN_W-1:0]               pin_s1;
    logic                           lclk_prev;
    logic [IDLE_W-1:0]              idle;
    logic                           cap_v;
    logic [PIN_W-1:0]               cap;
    logic                           csc_v;
    logic [WORD_W-1:0]              csc;
    logic                           gc_v;
    logic [WORD_W-1:0]              gc;
    logic                           gvs_last;
    logic [CH_W-1:0]                peak;
    logic [CH_W-1:0]                gain_auto;
    logic [CH_W-1:0]                blank_meas;
    logic                           ovf;
    logic [9:0]                     ctrl;
    logic [24:0]                    hsc;
    logic [24:0]                    vsc;
    logic                           fpol;
    logic [CH_W-1:0]                gain_man;
    logic [CH_W-1:0]                offs_man;
    logic [NUM_COEF-1:0][11:0]      coef;
    logic [2:0][CH_W-1:0]           cofs;
    logic [1:0]                     imask;
    logic [1:0]                     ipend;
    logic [1:0]                     stat_prev;
    cppf_ph_t                       ph;
    logic                           pclk;
    logic [WORD_W-1:0]              w;
    logic                           cph;
    logic [CNT_W-1:0]               hcnt;
    logic [CNT_W-1:0]               vcnt;
    logic                           field;
    logic [29:0]                    pix;
    logic                           hs_o;
    logic                           vs_o;
    logic                           fov_o;
    logic [31:0]                    rdata;
  } cppf_state_t;

  cppf_state_t       s_q;
  cppf_state_t       s_d;
  logic              lrise;
  logic              stall;
  logic              pop;
  logic              f_ir;
  logic              f_ov;
  logic [WORD_W-1:0] fw;
  logic              ddr;
  cppf_fmt_t         eff_fmt;
  cppf_in_t          mode;
  logic [29:0]       in3;
  logic [29:0]       csc3;
  logic [CH_W-1:0]   gain_use;
  logic [CH_W-1:0]   offs_use;
  logic [1:0]        stat;
  logic [1:0]        change;
  logic [31:0]       rd_val;

  // ==========================================================
  // Arithmetic helpers
  function automatic logic [9:0] sat10(input logic signed [24:0] v);
    if (v < 0)
      return 10'h000;
    if (v > $signed({15'h0000, CH_MAX}))
      return CH_MAX;
    return v[9:0];
  endfunction

  function automatic logic [9:0] csc_row(input logic [29:0] x,
                                         input logic [35:0] c,
                                         input logic [9:0]  o);
    logic signed [24:0] acc;
    acc = $signed({1'b0, x[29:20]}) * $signed(c[11:0])
        + $signed({1'b0, x[19:10]}) * $signed(c[23:12])
        + $signed({1'b0, x[9:0]})   * $signed(c[35:24]);
    return sat10((acc >>> 8) + $signed({15'h0000, o}));
  endfunction

  function automatic logic [9:0] gain_clamp(input logic [9:0] y,
                                            input logic [9:0] o,
                                            input logic [9:0] g);
    logic signed [24:0] acc;
    acc = ($signed({1'b0, y}) - $signed({1'b0, o}))
        * $signed({1'b0, g});
    return sat10((acc >>> 8) + $signed({15'h0000, BLANK_LEVEL}));
  endfunction

  function automatic logic in_win(input logic [CNT_W-1:0] cnt,
                                  input logic [24:0]      cfg);
    logic [CNT_W:0] lo;
    lo = {1'b0, cfg[CNT_W-1:0]};
    return ({1'b0, cnt} >= lo) &&
           ({1'b0, cnt} < lo + {1'b0, cfg[SYNC_WID_LSB +: CNT_W]});
  endfunction

  // Pixel word layout per output format; half selects DDR fall word
  function automatic logic [29:0] fmt_word(input logic [32:0] w,
                                           input cppf_fmt_t   f,
                                           input logic        cph,
                                           input logic        half);
    logic [9:0]  y;
    logic [9:0]  c;
    logic [29:0] r;
    y = w[29:20];
    c = cph ? w[9:0] : w[19:10];
    r = '0;
    unique case (f)
      FMT_SDR20: r = {y, c, 10'h000};
      FMT_SDR24: r = {y[9:2], 2'h0, w[19:12], 2'h0, w[9:2], 2'h0};
      FMT_SDR30: r = w[29:0];
      FMT_DDR8:  r = {half ? y[9:2] : c[9:2], 22'h000000};
      FMT_DDR10: r = {half ? y : c, 20'h00000};
      FMT_DDR12: r = half ? {w[15:12], w[9:2], 18'h00000}
                          : {y[9:2], w[19:16], 18'h00000};
      default:   r = {y[9:2], 2'h0, c[9:2], 2'h0, 10'h000};
    endcase
    return r;
  endfunction

  // ==========================================================
  // Input path and FIFO
  assign lrise = s_q.lclk_s[1] && !s_q.lclk_prev;
  assign stall = s_q.gc_v && !f_ir;
  assign mode  = cppf_in_t'(s_q.ctrl[CTRL_MODE_LSB +: 2]);

  always_comb
  begin
    unique case (mode)
      IN_YC422: in3 = {s_q.cap[19:0], s_q.cap[9:0]};
      IN_CVBS:  in3 = {s_q.cap[9:0], CHROMA_MID, CHROMA_MID};
      default:  in3 = {s_q.cap[23:16], 2'h0, s_q.cap[15:8], 2'h0,
                       s_q.cap[7:0], 2'h0};
    endcase
    if (mode == IN_YC422 || mode == IN_CVBS)
      csc3 = in3;
    else
      csc3 = {csc_row(in3, s_q.coef[2:0], s_q.cofs[0]),
              csc_row(in3, s_q.coef[5:3], s_q.cofs[1]),
              csc_row(in3, s_q.coef[8:6], s_q.cofs[2])};
  end

  assign gain_use = (s_q.ctrl[CTRL_GAIN_MAN] || !s_q.ctrl[CTRL_EMB_SYNC])
                  ? s_q.gain_man : s_q.gain_auto;
  assign offs_use = s_q.ctrl[CTRL_OFFS_MAN] ? s_q.offs_man
                                            : s_q.blank_meas;

  cppf_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (s_q.gc_v),
    .in_ready  (f_ir),
    .in_data   (s_q.gc),
    .out_valid (f_ov),
    .out_ready (s_q.ctrl[CTRL_EN] && s_q.ph == PH_LO),
    .out_data  (fw)
  );

  // ==========================================================
  // Output side and status
  assign eff_fmt = (mode == IN_CVBS) ? cppf_fmt_t'(s_q.ctrl[2:0])
                                     : FMT_SDR16;
  assign ddr     = eff_fmt[2];
  assign pop     = s_q.ctrl[CTRL_EN] && s_q.ph == PH_LO && f_ov;
  assign stat    = {s_q.ovf, s_q.idle != IDLE_W'(LINK_TIMEOUT_CYC)};
  assign change  = stat ^ s_q.stat_prev;

  always_comb
  begin
    rd_val = '0;
    unique case (reg_addr)
      REG_CTRL:  rd_val[9:0]  = s_q.ctrl;
      REG_HSYNC: rd_val[24:0] = s_q.hsc;
      REG_VSYNC: rd_val[24:0] = s_q.vsc;
      REG_FIELD: rd_val[0]    = s_q.fpol;
      REG_GAIN:  rd_val[9:0]  = s_q.gain_man;
      REG_OFFS:  rd_val[9:0]  = s_q.offs_man;
      REG_COFS:  rd_val[29:0] = s_q.cofs;
      REG_STAT:  rd_val = {10'h000, gain_use, 10'h000, stat};
      REG_IMASK: rd_val[1:0]  = s_q.imask;
      REG_IPEND: rd_val[1:0]  = s_q.ipend;
      default:   rd_val = '0;
    endcase
    for (int k = 0; k < NUM_COEF; k++)
      if (reg_addr == 8'(REG_COEF0 + 4 * k))
        rd_val[11:0] = s_q.coef[k];
  end

  always_comb
  begin
    s_d           = s_q;
    s_d.lclk_s    = {s_q.lclk_s[0], digital_port_clock_in};
    s_d.pin_s0    = {pixel_valid_in, frame_sync_in, line_sync_in,
                     pixel_data_in};
    s_d.pin_s1    = s_q.pin_s0;
    s_d.lclk_prev = s_q.lclk_s[1];
    if (lrise)
      s_d.idle = '0;
    else if (s_q.idle != IDLE_W'(LINK_TIMEOUT_CYC))
      s_d.idle = s_q.idle + 1'b1;
    // Pipeline: capture, matrix, gain and clamp
    if (!stall)
    begin
      s_d.cap_v = 1'b0;
      s_d.csc_v = s_q.cap_v;
      s_d.csc   = {s_q.cap[26:24], csc3};
      s_d.gc_v  = s_q.csc_v;
      s_d.gc    = {s_q.csc[32:30],
                   gain_clamp(s_q.csc[29:20], offs_use, gain_use),
                   s_q.csc[19:0]};
      if (s_q.csc_v && !s_q.csc[32])
        s_d.blank_meas = s_q.csc[29:20];
    end
    if (lrise)
    begin
      s_d.cap   = s_q.pin_s1;
      s_d.cap_v = 1'b1;
    end
    // Automatic gain loop, one step per frame
    if (s_q.gc_v && f_ir)
    begin
      s_d.gvs_last = s_q.gc[31];
      if (s_q.gc[32] && s_q.gc[29:20] > s_q.peak)
        s_d.peak = s_q.gc[29:20];
      if (s_q.gc[31] && !s_q.gvs_last)
      begin
        s_d.peak = '0;
        if (s_q.peak > PEAK_TARGET && s_q.gain_auto != '0)
          s_d.gain_auto = s_q.gain_auto - 1'b1;
        else if (s_q.peak < PEAK_TARGET && s_q.gain_auto != CH_MAX)
          s_d.gain_auto = s_q.gain_auto + 1'b1;
      end
    end
    // Output formatter
    if (!s_q.ctrl[CTRL_EN])
    begin
      s_d.ph   = PH_LO;
      s_d.pclk = 1'b0;
    end
    else if (s_q.ph == PH_LO)
    begin
      s_d.ph   = PH_HI;
      s_d.pclk = 1'b1;
      if (pop)
      begin
        s_d.w   = fw;
        s_d.cph = (fw[30] && !s_q.w[30]) ? 1'b0 : s_q.cph ^ s_q.w[32];
        if (fw[30] && !s_q.w[30])
          s_d.hcnt = '0;
        else if (s_q.hcnt != '1)
          s_d.hcnt = s_q.hcnt + 1'b1;
        if (fw[31] && !s_q.w[31])
        begin
          s_d.vcnt  = '0;
          s_d.field = !s_q.field;
        end
        else if (fw[30] && !s_q.w[30] && s_q.vcnt != '1)
          s_d.vcnt = s_q.vcnt + 1'b1;
        s_d.pix   = fmt_word(fw, eff_fmt, s_d.cph, 1'b0);
        s_d.hs_o  = in_win(s_d.hcnt, s_q.hsc) ^ s_q.hsc[SYNC_POL];
        s_d.vs_o  = in_win(s_d.vcnt, s_q.vsc) ^ s_q.vsc[SYNC_POL];
        s_d.fov_o = s_q.ctrl[CTRL_DE_SEL] ? fw[32]
                                          : s_d.field ^ s_q.fpol;
      end
      else if (s_q.ctrl[CTRL_DE_SEL])
        s_d.fov_o = 1'b0;
    end
    else
    begin
      s_d.ph   = PH_LO;
      s_d.pclk = 1'b0;
      if (ddr)
        s_d.pix = fmt_word(s_q.w, eff_fmt, s_q.cph, 1'b1);
    end
    // Status, interrupt, register writes
    s_d.stat_prev = stat;
    s_d.ovf       = s_q.ovf;
    s_d.ipend     = s_q.ipend;
    if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_OVF])
      s_d.ovf = 1'b0;
    if (reg_wr && reg_addr == REG_IPEND)
      s_d.ipend = s_q.ipend & ~reg_wdata[1:0];
    s_d.ovf   = s_d.ovf | (lrise && s_q.cap_v && stall);
    s_d.ipend = s_d.ipend | (change & s_q.imask);
    if (reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL:  s_d.ctrl     = reg_wdata[9:0];
        REG_HSYNC: s_d.hsc      = reg_wdata[24:0];
        REG_VSYNC: s_d.vsc      = reg_wdata[24:0];
        REG_FIELD: s_d.fpol     = reg_wdata[0];
        REG_GAIN:  s_d.gain_man = reg_wdata[9:0];
        REG_OFFS:  s_d.offs_man = reg_wdata[9:0];
        REG_COFS:  s_d.cofs     = reg_wdata[29:0];
        REG_IMASK: s_d.imask    = reg_wdata[1:0];
        default:   s_d.imask    = s_d.imask;
      endcase
      for (int k = 0; k < NUM_COEF; k++)
        if (reg_addr == 8'(REG_COEF0 + 4 * k))
          s_d.coef[k] = reg_wdata[11:0];
    end
    s_d.rdata = reg_rd ? rd_val : '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q           <= '0;
      s_q.ctrl      <= CTRL_RST;
      s_q.hsc       <= HSYNC_RST;
      s_q.vsc       <= VSYNC_RST;
      s_q.gain_man  <= GAIN_RST;
      s_q.gain_auto <= GAIN_RST;
      s_q.coef[0]   <= COEF_UNITY;
      s_q.coef[4]   <= COEF_UNITY;
      s_q.coef[8]   <= COEF_UNITY;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata               = s_q.rdata;
  assign line_locked_pixel_clock = s_q.pclk;
  assign pixel_out               = s_q.pix;
  assign hsync_out               = s_q.hs_o;
  assign vsync_out               = s_q.vs_o;
  assign field_or_valid_out      = s_q.fov_o;
  assign irq_out                 = |s_q.ipend;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_sdr_word_rate:
    assert property (!$past(ddr) && $changed(pixel_out)
                     |-> $rose(line_locked_pixel_clock))
    else $error("SDR word changed off the rising clock");
  a_ddr_both_edges:
    assert property ($past(ddr) && $changed(pixel_out)
                     |-> $changed(line_locked_pixel_clock))
    else $error("DDR word changed without a clock edge");
  a_sdr16_padding:
    assert property (pop && eff_fmt == FMT_SDR16
                     |=> pixel_out[21:20] == 2'h0
                         && pixel_out[11:0] == 12'h000)
    else $error("SDR16 word has bits outside its lanes");
  a_ddr8_lanes:
    assert property (pop && eff_fmt == FMT_DDR8
                     |=> pixel_out[21:0] == 22'h000000)
    else $error("DDR8 word has bits outside its lanes");
  a_recv_422_out:
    assert property (pop && mode != IN_CVBS |=> pixel_out[9:0] == 10'h000)
    else $error("Receiver pixel not in 16-bit 4:2:2 lanes");
  a_sync_with_word:
    assert property ($changed(hsync_out) || $changed(vsync_out)
                     |-> $rose(line_locked_pixel_clock))
    else $error("Sync output moved off the word edge");
  a_valid_on_field:
    assert property (pop && s_q.ctrl[CTRL_DE_SEL]
                     |=> field_or_valid_out == $past(fw[32]))
    else $error("Field pin does not carry data valid");
  a_manual_gain:
    assert property (reg_rd && reg_addr == REG_STAT
                     && !s_q.ctrl[CTRL_EMB_SYNC]
                     |=> reg_rdata[STAT_GAIN_LSB +: CH_W]
                         == $past(s_q.gain_man))
    else $error("Gain not manual without embedded sync");
  a_irq_raise:
    assert property (|(change & s_q.imask) |=> irq_out)
    else $error("Enabled status change did not raise interrupt");
  a_link_capture:
    assert property (lrise |=> s_q.cap_v && s_q.cap == $past(s_q.pin_s1))
    else $error("Port clock edge did not capture the pins");
endmodule

//--- testbench/cppf_rx_model.sv
/*
  Behavioural model of the external receiver on the digital input port.
  Assumes the bench calls send once per pixel; the link clock idles low.
*/
`timescale 1ns/1ps

module cppf_rx_model (
  // Link side
  output logic        link_clk,
  output logic [23:0] data,
  output logic        hs,
  output logic        vs,
  output logic        valid
);

  initial
  begin
    link_clk = 1'b0;
    data     = 24'h000000;
    hs       = 1'b0;
    vs       = 1'b0;
    valid    = 1'b0;
  end

  // ==========================================================
  // One pixel per 800 ns link cycle, off the core clock phase
  task automatic send(input logic [23:0] d, input logic v, input logic h);
    #37;
    data  = d;
    valid = v;
    hs    = h;
    #350 link_clk = 1'b1;
    #400 link_clk = 1'b0;
    data  = ~d;
    valid = ~v;
    #13;
  endtask

endmodule

//--- testbench/tb.sv
/*
  Self-checking bench of the component pixel port formatter.
  Assumes the package, design and receiver model are compiled first.
*/
`timescale 1ns/1ps

module tb;
  import cppf_pkg::*;

  logic        core_clk, rst, reg_wr, reg_rd, llpc, hs, vs, fov;
  logic        irq, link_clk, valid, llpc_q, rd_q, hso, vso;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, exp_v, exp_m;
  logic [23:0] pix_in;
  logic [29:0] pixel_out;
  logic [31:0] rq_v[$];
  logic [31:0] rq_m[$];
  logic [31:0] pq[$];
  logic [9:0]  y, c, ey;
  int          errors, check_count, seed, i, p, t;

  always #50 core_clk = ~core_clk;

  cppf_rx_model u_rx (.link_clk(link_clk), .data(pix_in), .hs(hs),
    .vs(vs), .valid(valid));

  cppf_top u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .digital_port_clock_in(link_clk),
    .pixel_data_in(pix_in), .line_sync_in(hs), .frame_sync_in(vs),
    .pixel_valid_in(valid), .line_locked_pixel_clock(llpc),
    .pixel_out(pixel_out), .hsync_out(hso), .vsync_out(vso),
    .field_or_valid_out(fov), .irq_out(irq));

  // ==========================================================
  // Checking and closing
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_drain;
    int n;
    for (n = 0; n < 3000; n++)
    begin
      if (pq.size() == 0 && rq_v.size() == 0)
        break;
      @(posedge core_clk);
    end
    if (n == 3000)
    begin
      errors++;
      $display("mismatch drain expected 0 seen %0d", pq.size());
      stop_test();
    end
  endtask

  // ==========================================================
  // Register port master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    rq_v.push_back(e);
    rq_m.push_back(m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // ==========================================================
  // Output watcher
  always @(posedge core_clk)
  begin
    llpc_q <= llpc;
    rd_q   <= reg_rd;
    if (rd_q)
    begin
      exp_v = rq_v.pop_front();
      exp_m = rq_m.pop_front();
      check("reg_rdata", reg_rdata & exp_m, exp_v);
    end
    if (llpc === 1'b1 && llpc_q === 1'b0 && fov === 1'b1)
      check("pixel", {vso, hso, pixel_out}, pq.pop_front());
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 72;
    errors = 0;
    check_count = 0;
    core_clk = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h00000000, 32'hffffffff);
    rd(REG_HSYNC, {7'h00, HSYNC_RST}, 32'hffffffff);
    rd(REG_VSYNC, {7'h00, VSYNC_RST}, 32'hffffffff);
    wr(8'hfc, $random(seed));
    rd(8'hfc, 32'h00000000, 32'hffffffff);
    wr(REG_FIELD, 32'h00000001);
    rd(REG_FIELD, 32'h00000001, 32'h00000001);
    $display("test registers done");
    for (p = 0; p < 3; p++)
    begin
      wr(REG_GAIN, p ? 32'h00000080 : 32'h00000100);
      wr(REG_OFFS, p ? 32'h00000020 : 32'h00000000);
      wr(REG_HSYNC, {7'h00, p[0], 24'h003002});
      wr(REG_CTRL, p == 2 ? 32'h000003bc
                          : (p ? 32'h00000330 : 32'h000003b0));
      rd(REG_STAT, {10'h000, p ? 10'h080 : 10'h100, 12'h000},
         32'h003ff000);
      for (i = 0; i < 12; i++)
      begin
        y = (i == 0) ? 10'h3ff : 10'h040 + 10'($random(seed) & 32'h1ff);
        c = 10'($random(seed));
        t = ((int'(y) - (p ? 32 : 0)) * (p ? 128 : 256)) / 256 + 64;
        ey = (t > 1023) ? 10'h3ff : 10'(t);
        if (i != 5)
          pq.push_back({1'(p < 2), 1'((i > 1 && i < 5) ^ p[0]),
                        p == 2 ? {CHROMA_MID[9:2], 22'h000000}
                               : {ey[9:2], 2'b00, c[9:2], 12'h000}});
        u_rx.send({4'h0, y, c}, i != 5, i == 0);
      end
      wait_drain();
      $display("test pixels pass %0d done", p);
    end
    wr(REG_IMASK, 32'h00000002);
    wr(REG_CTRL, 32'h000001b0);
    for (i = 0; i < 24; i++)
      u_rx.send(24'($random(seed)), 1'b1, 1'b0);
    repeat (8) @(posedge core_clk);
    check("irq_out", {31'h0, irq}, 32'h00000001);
    rd(REG_STAT, 32'h00000002, 32'h00000002);
    wr(REG_STAT, 32'h00000002);
    repeat (6) @(posedge core_clk);
    rd(REG_STAT, 32'h00000000, 32'h00000002);
    wr(REG_IPEND, 32'h00000003);
    repeat (4) @(posedge core_clk);
    check("irq_out", {31'h0, irq}, 32'h00000000);
    wait_drain();
    $display("test overflow done");
    stop_test();
  end

endmodule
